// ---- fbc_pkg.sv ----
// constants for the fifo batch configuration block
package fbc_pkg;
  // register indices on the register port
  localparam logic [3:0] ADDR_WTM        = 4'h0;
  localparam logic [3:0] ADDR_COMPR      = 4'h1;
  localparam logic [3:0] ADDR_BDR        = 4'h2;
  localparam logic [3:0] ADDR_MODE       = 4'h3;
  localparam logic [3:0] ADDR_CNT_HI     = 4'h4;
  localparam logic [3:0] ADDR_CNT_LO     = 4'h5;
  localparam logic [3:0] ADDR_STATUS1    = 4'h6;
  localparam logic [3:0] ADDR_STATUS2    = 4'h7;
  // reset values
  localparam logic [7:0] RST_REG         = 8'h00;
  // field positions
  localparam int STOP_WTM_BIT            = 7;
  localparam int COMPR_RT_BIT            = 6;
  localparam int CFG_CHG_BIT             = 4;
  localparam int UNC_RATE_LSB            = 1;
  localparam int CH2_BATCH_BIT           = 0;
  localparam int GY_RATE_LSB             = 4;
  localparam int XL_RATE_LSB             = 0;
  localparam int TS_DEC_LSB              = 6;
  localparam int TEMP_RATE_LSB           = 4;
  localparam int EIS_EN_BIT              = 3;
  localparam int MODE_LSB                = 0;
  localparam int TRIG_LSB                = 5;
  localparam int CNT_TH_HI_LSB           = 0;
  // sizes
  localparam int ENTRY_BYTES             = 7;
  localparam int FIFO_ENTRIES            = 256;
  localparam int STAGE_DEPTH             = 16;
  // batch rate, decimation and trigger codes
  localparam logic [3:0] RATE_OFF        = 4'h0;
  localparam logic [3:0] RATE_MAX_CODE   = 4'hc;
  localparam logic [1:0] UNC_NEVER       = 2'h0;
  localparam logic [1:0] TS_OFF          = 2'h0;
  localparam logic [1:0] TS_DIV1         = 2'h1;
  localparam logic [1:0] TS_DIV8         = 2'h2;
  localparam logic [1:0] TRIG_XL         = 2'h0;
  localparam logic [1:0] TRIG_GY         = 2'h1;
  // tick counts for forced and decimation periods
  localparam logic [5:0] UNC_P8          = 6'h08;
  localparam logic [5:0] UNC_P16         = 6'h10;
  localparam logic [5:0] UNC_P32         = 6'h20;
  localparam logic [5:0] TS_P8           = 6'h08;
  localparam logic [5:0] TS_P32          = 6'h20;
  // entry kinds pushed to storage
  typedef enum logic [2:0] {
    FBC_K_ACCEL = 3'b000,
    FBC_K_GYRO  = 3'b001,
    FBC_K_TS    = 3'b010,
    FBC_K_TEMP  = 3'b011,
    FBC_K_CFG   = 3'b100,
    FBC_K_CH2   = 3'b101,
    FBC_K_EIS   = 3'b110
  } fbc_kind_e;
endpackage

// ---- fbc_stage_fifo.sv ----
// small staging fifo with valid/ready on both sides
`timescale 1ns/100ps
module fbc_stage_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign in_ready  = (count != (AW+1)'(DEPTH)); // compare at full counter width
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  // storage and pointers
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (ce) begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr      <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ---- fbc_fifo_batch_cfg.sv ----
// fifo batch configuration, batch pacing and sample counter
`timescale 1ns/100ps
module fbc_fifo_batch_cfg
  import fbc_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_ENTRIES,
  parameter int STG_DEPTH  = STAGE_DEPTH
) (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       ce,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  input  wire logic [3:0] rate_tick,
  input  wire logic       accel_sample,
  input  wire logic       gyro_sample,
  input  wire logic       eis_sample,
  input  wire logic       ch2_sample,
  input  wire logic       hub_tick,
  input  wire logic       temp_tick,
  input  wire logic       accel_dual_channel_enable,
  input  wire logic       state_machine_batch_go,
  input  wire logic       entry_read,
  output logic [2:0]      entry_kind,
  output logic            entry_compress,
  output logic            entry_valid,
  output logic [2:0]      fifo_mode,
  output logic            watermark_flag,
  output logic            sample_counter_flag,
  output logic            fifo_full
);
  // rate_tick is a spare input; its bits are gathered below and otherwise unused
  logic [7:0] watermark_threshold;
  logic       stop_at_watermark;
  logic       runtime_compress_enable;
  logic       config_change_batch_enable;
  logic       accel_ch2_batch_from_state_machine;
  logic [1:0] forced_uncompressed_rate;
  logic [3:0] gyro_batch_rate;
  logic [3:0] accel_batch_rate;
  logic [1:0] timestamp_decimation;
  logic [1:0] temperature_batch_rate;
  logic       gyro_stabilizer_batch_enable;
  logic [2:0] mode_field;
  logic [1:0] sample_counter_trigger;
  logic [9:0] sample_counter_threshold;
  logic [9:0] sample_count;
  logic [8:0] level;
  logic [8:0] cap;
  logic       room;
  logic       accel_on;
  logic       gyro_on;
  logic       ch2_on;
  logic       eis_on;
  logic [3:0] max_batch_rate;
  logic       max_tick;
  logic [5:0] ts_cnt;
  logic [5:0] ts_period;
  logic [5:0] unc_cnt;
  logic [5:0] unc_period;
  logic       force_unc;
  logic       cfg_pending;
  logic       trig_hit;
  logic [2:0] push_kind;
  logic       push_valid;
  logic       push_ready;
  logic       stg_valid;
  logic [2:0] stg_kind;
  logic       stg_take;
  logic       temp_go;
  logic       unused_hub;

  ////////////////////////////////////////////////////////////////////////
  // register writes; codes 13..15 are stored as written and treated as off by the enables
  always_ff @(posedge clk) begin
    if (srst) begin
      watermark_threshold                <= RST_REG;
      stop_at_watermark                  <= 1'b0;
      runtime_compress_enable            <= 1'b0;
      config_change_batch_enable         <= 1'b0;
      accel_ch2_batch_from_state_machine <= 1'b0;
      forced_uncompressed_rate           <= UNC_NEVER;
      gyro_batch_rate                    <= RATE_OFF;
      accel_batch_rate                   <= RATE_OFF;
      timestamp_decimation               <= TS_OFF;
      temperature_batch_rate             <= 2'h0;
      gyro_stabilizer_batch_enable       <= 1'b0;
      mode_field                         <= 3'h0;
      sample_counter_trigger             <= TRIG_XL;
      sample_counter_threshold           <= 10'h000;
    end else if (ce && reg_wr) begin
      case (reg_addr)
        ADDR_WTM: watermark_threshold <= reg_wdata;
        ADDR_COMPR: begin
          stop_at_watermark                  <= reg_wdata[STOP_WTM_BIT];
          runtime_compress_enable            <= reg_wdata[COMPR_RT_BIT];
          config_change_batch_enable         <= reg_wdata[CFG_CHG_BIT];
          forced_uncompressed_rate           <= reg_wdata[UNC_RATE_LSB +: 2];
          accel_ch2_batch_from_state_machine <= reg_wdata[CH2_BATCH_BIT];
        end
        ADDR_BDR: begin
          gyro_batch_rate  <= reg_wdata[GY_RATE_LSB +: 4];
          accel_batch_rate <= reg_wdata[XL_RATE_LSB +: 4];
        end
        ADDR_MODE: begin
          timestamp_decimation         <= reg_wdata[TS_DEC_LSB +: 2];
          temperature_batch_rate       <= reg_wdata[TEMP_RATE_LSB +: 2];
          gyro_stabilizer_batch_enable <= reg_wdata[EIS_EN_BIT];
          mode_field                   <= reg_wdata[MODE_LSB +: 3];
        end
        ADDR_CNT_HI: begin
          sample_counter_trigger         <= reg_wdata[TRIG_LSB +: 2];
          sample_counter_threshold[9:8]  <= reg_wdata[CNT_TH_HI_LSB +: 2];
        end
        ADDR_CNT_LO: sample_counter_threshold[7:0] <= reg_wdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // enables and the fastest batch rate
  always_comb begin
    accel_on = (accel_batch_rate != RATE_OFF)
               && (accel_batch_rate <= RATE_MAX_CODE);
    gyro_on  = (gyro_batch_rate != RATE_OFF)
               && (gyro_batch_rate <= RATE_MAX_CODE);
    ch2_on   = accel_ch2_batch_from_state_machine && accel_dual_channel_enable
               && state_machine_batch_go;
    eis_on   = gyro_stabilizer_batch_enable;
    max_batch_rate = RATE_OFF;
    if (accel_on && accel_batch_rate > max_batch_rate) max_batch_rate = accel_batch_rate;
    if (gyro_on && gyro_batch_rate > max_batch_rate) max_batch_rate = gyro_batch_rate;
  end

  // the max-rate event: any batched accel, gyro, ch2 or eis sample, or a hub tick
  assign max_tick = (accel_on && accel_sample) || (gyro_on && gyro_sample)
                    || (ch2_on && ch2_sample) || (eis_on && eis_sample)
                    || hub_tick;
  assign unused_hub = |rate_tick;

  // decimation and forced-uncompressed periods
  always_comb begin
    case (timestamp_decimation)
      TS_DIV1: ts_period = 6'h01;
      TS_DIV8: ts_period = TS_P8;
      default: ts_period = TS_P32;
    endcase
    case (forced_uncompressed_rate)
      2'h1:    unc_period = UNC_P8;
      2'h2:    unc_period = UNC_P16;
      default: unc_period = UNC_P32;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // timestamp decimation and forced-uncompressed counters
  always_ff @(posedge clk) begin
    if (srst) begin
      ts_cnt  <= 6'h00;
      unc_cnt <= 6'h00;
    end else if (ce) begin
      // idle at zero while timestamps are off, so the first event after enabling emits one if it is a hub tick that no sample or config entry outranks
      if (timestamp_decimation == TS_OFF) begin
        ts_cnt <= 6'h00;
      end else if (max_tick) begin
        ts_cnt <= (ts_cnt + 6'h01 >= ts_period) ? 6'h00 : ts_cnt + 6'h01;
      end
      if (max_tick) begin
        unc_cnt <= (unc_cnt + 6'h01 >= unc_period) ? 6'h00 : unc_cnt + 6'h01;
      end
    end
  end
  assign force_unc = (forced_uncompressed_rate != UNC_NEVER) && (unc_cnt == 6'h00);

  // config change pending: set on rate or mode register writes while config-change batching is on, cleared once pushed
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_pending <= 1'b0;
    end else if (ce) begin
      if (reg_wr && (reg_addr == ADDR_BDR || reg_addr == ADDR_MODE)
          && config_change_batch_enable) begin
        cfg_pending <= 1'b1;
      end else if (push_valid && push_ready && push_kind == FBC_K_CFG) begin
        cfg_pending <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // entry selection, one per cycle, fixed priority
  assign temp_go = (temperature_batch_rate != 2'h0) && temp_tick;
  always_comb begin
    push_valid = 1'b1;
    push_kind  = FBC_K_ACCEL;
    if (cfg_pending) push_kind = FBC_K_CFG;
    else if (accel_on && accel_sample) push_kind = FBC_K_ACCEL;
    else if (gyro_on && gyro_sample) push_kind = FBC_K_GYRO;
    else if (ch2_on && ch2_sample) push_kind = FBC_K_CH2;
    else if (eis_on && eis_sample) push_kind = FBC_K_EIS;
    else if (timestamp_decimation != TS_OFF && max_tick && ts_cnt == 6'h00)
      push_kind = FBC_K_TS;
    else if (temp_go) push_kind = FBC_K_TEMP;
    else push_valid = 1'b0;
  end

  fbc_stage_fifo #(.WIDTH(3), .DEPTH(STG_DEPTH)) u_stage (
    .clk       (clk),
    .srst      (srst),
    .ce        (ce),
    .in_data   (push_kind),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .out_data  (stg_kind),
    .out_valid (stg_valid),
    .out_ready (stg_take)
  );

  ////////////////////////////////////////////////////////////////////////
  // storage level in entries, capped by stop-at-watermark
  assign cap  = stop_at_watermark ? {1'b0, watermark_threshold} : 9'(FIFO_DEPTH);
  assign room = level < cap;
  assign stg_take = stg_valid && room; // stall staging when storage is at its cap
  always_ff @(posedge clk) begin
    if (srst) begin
      level <= 9'h000;
    end else if (ce) begin
      level <= level + 9'(stg_take) - 9'(entry_read && level != 9'h000);
    end
  end

  // entry strobe to storage
  always_ff @(posedge clk) begin
    if (srst) begin
      entry_valid    <= 1'b0;
      entry_kind     <= FBC_K_ACCEL;
      entry_compress <= 1'b0;
    end else if (ce) begin
      entry_valid    <= stg_take;
      if (stg_take) entry_kind <= stg_kind; // never show an unwritten stage word
      entry_compress <= stg_take && runtime_compress_enable && !force_unc
                        && (stg_kind == FBC_K_ACCEL || stg_kind == FBC_K_GYRO);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sample counter on real samples of the chosen trigger
  always_comb begin
    case (sample_counter_trigger)
      TRIG_XL: trig_hit = stg_take && stg_kind == FBC_K_ACCEL;
      TRIG_GY: trig_hit = stg_take && stg_kind == FBC_K_GYRO;
      default: trig_hit = stg_take && stg_kind == FBC_K_EIS;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sample_count <= 10'h000;
    end else if (ce) begin
      if (level == 9'h000 && !stg_take) sample_count <= 10'h000;
      else if (trig_hit) sample_count <= sample_count + 10'h001;
    end
  end

  // counter flag: set wins over clear-on-read of the second status
  always_ff @(posedge clk) begin
    if (srst) begin
      sample_counter_flag <= 1'b0;
    end else if (ce) begin
      if (trig_hit && sample_count + 10'h001 == sample_counter_threshold)
        sample_counter_flag <= 1'b1;
      else if (reg_rd && reg_addr == ADDR_STATUS2)
        sample_counter_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status outputs and read data
  always_ff @(posedge clk) begin
    if (srst) begin
      watermark_flag <= 1'b0;
      fifo_full      <= 1'b0;
      fifo_mode      <= 3'h0;
      reg_rdata      <= RST_REG;
    end else if (ce) begin
      watermark_flag <= (level >= {1'b0, watermark_threshold});
      fifo_full      <= !room;
      fifo_mode      <= mode_field;
      case (reg_addr)
        ADDR_WTM:     reg_rdata <= watermark_threshold;
        ADDR_COMPR:   reg_rdata <= {stop_at_watermark, runtime_compress_enable, 1'b0,
                                    config_change_batch_enable, 1'b0,
                                    forced_uncompressed_rate,
                                    accel_ch2_batch_from_state_machine};
        ADDR_BDR:     reg_rdata <= {gyro_batch_rate, accel_batch_rate};
        ADDR_MODE:    reg_rdata <= {timestamp_decimation, temperature_batch_rate,
                                    gyro_stabilizer_batch_enable, mode_field};
        ADDR_CNT_HI:  reg_rdata <= {1'b0, sample_counter_trigger, 3'h0,
                                    sample_counter_threshold[9:8]};
        ADDR_CNT_LO:  reg_rdata <= sample_counter_threshold[7:0];
        ADDR_STATUS1: reg_rdata <= level[7:0];
        ADDR_STATUS2: reg_rdata <= {watermark_flag, 2'h0, sample_counter_flag,
                                    3'h0, level[8]};
        default:      reg_rdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  chk_wtm_flag: assert property (@(posedge clk) disable iff (srst)
    ce ##1 1'b1 |-> watermark_flag == ($past(level) >= {1'b0, $past(watermark_threshold)}))
    else $error("watermark flag does not track level");
  chk_stop_cap: assert property (@(posedge clk) disable iff (srst)
    stop_at_watermark && level >= {1'b0, watermark_threshold} |-> !stg_take)
    else $error("entry stored past watermark cap");
  chk_compress_off: assert property (@(posedge clk) disable iff (srst)
    ce && !runtime_compress_enable |=> !entry_compress)
    else $error("compression while disabled");
  chk_ctr_clear: assert property (@(posedge clk) disable iff (srst)
    ce && level == 9'h000 && !stg_take |=> sample_count == 10'h000)
    else $error("counter not cleared on empty");
  chk_ctr_flag: assert property (@(posedge clk) disable iff (srst)
    ce && trig_hit && sample_count + 10'h001 == sample_counter_threshold
    |=> sample_counter_flag)
    else $error("counter flag missed");
  chk_ctr_real: assert property (@(posedge clk) disable iff (srst)
    ce && !trig_hit && !(level == 9'h000 && !stg_take) |=> $stable(sample_count))
    else $error("counter moved without a sample");
  chk_rate_fold: assert property (@(posedge clk) disable iff (srst)
    accel_batch_rate > RATE_MAX_CODE |-> !accel_on)
    else $error("reserved rate code batched");
  chk_ch2_gate: assert property (@(posedge clk) disable iff (srst)
    push_valid && push_kind == FBC_K_CH2 |-> accel_dual_channel_enable && state_machine_batch_go)
    else $error("channel two batched without dual mode");
  chk_level_cap: assert property (@(posedge clk) disable iff (srst)
    level <= 9'(FIFO_DEPTH))
    else $error("level above storage depth");
  chk_eis_gate: assert property (@(posedge clk) disable iff (srst)
    push_valid && push_kind == FBC_K_EIS |-> gyro_stabilizer_batch_enable)
    else $error("stabilizer data batched while disabled");
  chk_ts_gate: assert property (@(posedge clk) disable iff (srst)
    push_valid && push_kind == FBC_K_TS |-> timestamp_decimation != TS_OFF)
    else $error("timestamp batched while decimation off");
  chk_temp_gate: assert property (@(posedge clk) disable iff (srst)
    push_valid && push_kind == FBC_K_TEMP |-> temperature_batch_rate != 2'h0)
    else $error("temperature batched while off");
  chk_mode_out: assert property (@(posedge clk) disable iff (srst)
    ce |=> fifo_mode == $past(mode_field))
    else $error("mode output does not follow register");
  chk_full_flag: assert property (@(posedge clk) disable iff (srst)
    ce |=> fifo_full == ($past(level) >= $past(cap)))
    else $error("full flag does not track the cap");
endmodule

// ---- fbc_host_model.sv ----
// host model that drains batched entries and tallies what it saw
`timescale 1ns/100ps
module fbc_host_model
  import fbc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       stall,
  input  wire logic       entry_valid,
  input  wire logic [2:0] entry_kind,
  input  wire logic       entry_compress,
  output logic            entry_read
);
  int         n_seen = 0;
  int         n_plain = 0;
  int         pending = 0;
  logic [2:0] last_kind = 3'h7;

  initial entry_read = 1'b0;

  // count stored entries, drain one per cycle unless the bench stalls us
  always @(posedge clk) begin
    pending = pending + int'(entry_valid === 1'b1) - int'(entry_read === 1'b1);
    entry_read <= !stall && (pending > 0);
    if (entry_valid === 1'b1) begin
      n_seen++;
      last_kind <= entry_kind;
      if (entry_compress === 1'b0 && entry_kind inside {FBC_K_ACCEL, FBC_K_GYRO}) begin
        n_plain++;
      end
    end
  end
endmodule

// ---- tb_fbc_fifo_batch_cfg.sv ----
// self-checking bench for the fifo batch configuration block
`timescale 1ns/100ps
module tb_fbc_fifo_batch_cfg
  import fbc_pkg::*;
;
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [5:0] ev = 6'h00;
  logic       dual = 1'b1;
  logic       go = 1'b1;
  logic       ce = 1'b1;
  logic       stall = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] rd_val;
  logic [7:0] lfsr = 8'h54;
  logic [2:0] entry_kind;
  logic [2:0] fifo_mode;
  logic       entry_compress;
  logic       entry_valid;
  logic       entry_read;
  logic       watermark_flag;
  logic       sample_counter_flag;
  logic       fifo_full;
  int         n_errors = 0;
  int         n_checks = 0;
  // register, data, sample lines, expected entry count and kind
  localparam logic [21:0] TBL [12] = '{
    {4'h2, 8'h01, 6'h01, 1'b1, FBC_K_ACCEL}, {4'h2, 8'h0d, 6'h01, 1'b0, FBC_K_ACCEL},
    {4'h2, 8'h00, 6'h01, 1'b0, FBC_K_ACCEL}, {4'h2, 8'hc0, 6'h02, 1'b1, FBC_K_GYRO},
    {4'h3, 8'h00, 6'h04, 1'b0, FBC_K_EIS},   {4'h3, 8'h08, 6'h04, 1'b1, FBC_K_EIS},
    {4'h3, 8'h00, 6'h10, 1'b0, FBC_K_TEMP},  {4'h3, 8'h30, 6'h10, 1'b1, FBC_K_TEMP},
    {4'h1, 8'h00, 6'h08, 1'b0, FBC_K_CH2},   {4'h1, 8'h01, 6'h08, 1'b1, FBC_K_CH2},
    {4'h3, 8'h00, 6'h20, 1'b0, FBC_K_TS},    {4'h3, 8'h40, 6'h20, 1'b1, FBC_K_TS}};

  initial forever #12.5 clk = ~clk;

  fbc_fifo_batch_cfg u_dut (.clk(clk), .srst(srst), .ce(ce), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .rate_tick(4'h0), .accel_sample(ev[0]), .gyro_sample(ev[1]), .eis_sample(ev[2]),
    .ch2_sample(ev[3]), .hub_tick(ev[5]), .temp_tick(ev[4]),
    .accel_dual_channel_enable(dual), .state_machine_batch_go(go),
    .entry_read(entry_read), .entry_kind(entry_kind), .entry_compress(entry_compress),
    .entry_valid(entry_valid), .fifo_mode(fifo_mode), .watermark_flag(watermark_flag),
    .sample_counter_flag(sample_counter_flag), .fifo_full(fifo_full));

  fbc_host_model u_host (.clk(clk), .stall(stall), .entry_valid(entry_valid),
    .entry_kind(entry_kind), .entry_compress(entry_compress), .entry_read(entry_read));

  ////////////////////////////////////////////////////////////////////////////////
  // expectation helpers and bus tasks
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [7:0] rw_mask(input logic [3:0] a);
    case (a)
      ADDR_COMPR:  return 8'hd7;
      ADDR_CNT_HI: return 8'h63;
      ADDR_WTM, ADDR_BDR, ADDR_MODE, ADDR_CNT_LO: return 8'hff;
      default:     return 8'h00;
    endcase
  endfunction
  function automatic logic [9:0] exp_plain(input int u);
    return (u == 4) ? 10'd32 : (u == 0) ? 10'd0 : 10'(32 >> (u + 2));
  endfunction
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  // samples are spaced well below any output rate
  task automatic pulse(input logic [5:0] m, input int n);
    repeat (n) begin
      @(posedge clk);
      ev <= m;
      @(posedge clk);
      ev <= 6'h00;
      @(posedge clk);
    end
    repeat (6) @(posedge clk);
  endtask
  task automatic flags(input logic [1:0] exp);
    check({8'h00, watermark_flag, sample_counter_flag}, {8'h00, exp});
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [3:0] ad;
    logic [7:0] d;
    logic [5:0] m;
    logic       c;
    logic [2:0] kd;
    int         b;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    for (int a = 0; a < 6; a++) begin
      rd(4'(a));
      check({2'b00, rd_val}, 10'h000);
    end
    // an empty store already reaches the zero threshold left by reset
    check({7'h0, watermark_flag, sample_counter_flag, fifo_full}, 10'h004);
    $display("test reset done");
    for (int i = 0; i < 28; i++) begin
      ad = (i % 7 == 6) ? 4'h9 : 4'(i % 7);
      lfsr = lfsr_next(lfsr);
      wr(ad, lfsr);
      rd(ad);
      check({2'b00, rd_val}, {2'b00, lfsr & rw_mask(ad)});
      if (ad == ADDR_MODE) check({7'h0, fifo_mode}, {7'h0, lfsr[2:0]});
    end
    for (int a = 0; a < 6; a++) wr(4'(a), 8'h00);
    repeat (20) @(posedge clk);
    $display("test registers done");
    // channel 2 also needs dual mode and the state machine go
    foreach (TBL[i]) begin
      {ad, d, m, c, kd} = TBL[i];
      wr(ad, d);
      b = u_host.n_seen;
      pulse(m, 1);
      check(10'(u_host.n_seen - b), {9'h0, c});
      if (c) check({7'h0, u_host.last_kind}, {7'h0, kd});
      wr(ad, 8'h00);
    end
    // channel 2 stays out when either dual mode or the state machine go is missing
    wr(ADDR_COMPR, 8'h01);
    for (int k = 0; k < 2; k++) begin
      dual <= k[0];
      go   <= !k[0];
      b = u_host.n_seen;
      pulse(6'h08, 1);
      check(10'(u_host.n_seen - b), 10'h000);
    end
    dual <= 1'b1;
    go   <= 1'b1;
    wr(ADDR_COMPR, 8'h10);
    b = u_host.n_seen;
    wr(ADDR_BDR, 8'h00);
    repeat (8) @(posedge clk);
    check(10'(u_host.n_seen - b), 10'h001);
    check({7'h0, u_host.last_kind}, {7'h0, FBC_K_CFG});
    wr(ADDR_COMPR, 8'h00);
    $display("test kinds done");
    wr(ADDR_BDR, 8'h01);
    for (int u = 0; u < 5; u++) begin
      wr(ADDR_COMPR, (u == 4) ? 8'h00 : {2'b01, 3'h0, 2'(u), 1'b0});
      b = u_host.n_plain;
      pulse(6'h01, 32);
      check(10'(u_host.n_plain - b), exp_plain(u));
    end
    $display("test compression done");
    stall <= 1'b1;
    wr(ADDR_BDR, 8'h11);
    wr(ADDR_WTM, 8'h03);
    wr(ADDR_CNT_LO, 8'h02);
    pulse(6'h02, 1);
    pulse(6'h01, 1);
    flags(2'b00);
    pulse(6'h01, 1);
    flags(2'b11);
    rd(ADDR_STATUS2);
    check({2'b00, rd_val}, 10'h090);
    rd(ADDR_STATUS1);
    check({2'b00, rd_val}, 10'h003);
    flags(2'b10);
    wr(ADDR_CNT_LO, 8'h03);
    stall <= 1'b0;
    repeat (12) @(posedge clk);
    rd(ADDR_STATUS1);
    check({2'b00, rd_val}, 10'h000);
    stall <= 1'b1;
    pulse(6'h01, 1);
    flags(2'b00);
    pulse(6'h01, 2);
    flags(2'b11);
    rd(ADDR_STATUS2);
    stall <= 1'b0;
    repeat (12) @(posedge clk);
    stall <= 1'b1;
    wr(ADDR_CNT_HI, 8'h20);
    wr(ADDR_CNT_LO, 8'h01);
    pulse(6'h01, 1);
    check({9'h0, sample_counter_flag}, 10'h000);
    pulse(6'h02, 1);
    check({9'h0, sample_counter_flag}, 10'h001);
    // stabilizer trigger: gyro samples no longer count
    rd(ADDR_STATUS2);
    wr(ADDR_MODE, 8'h08);
    wr(ADDR_CNT_HI, 8'h60);
    wr(ADDR_CNT_LO, 8'h02);
    pulse(6'h02, 1);
    check({9'h0, sample_counter_flag}, 10'h000);
    pulse(6'h04, 1);
    check({9'h0, sample_counter_flag}, 10'h001);
    $display("test counter done");
    stall <= 1'b0;
    repeat (12) @(posedge clk);
    stall <= 1'b1;
    wr(ADDR_WTM, 8'h02);
    wr(ADDR_COMPR, 8'h80);
    pulse(6'h01, 4);
    rd(ADDR_STATUS1);
    check({2'b00, rd_val}, 10'h002);
    check({9'h0, fifo_full}, 10'h001);
    wr(ADDR_COMPR, 8'h00);
    stall <= 1'b0;
    repeat (12) @(posedge clk);
    $display("test stop at watermark done");
    // a write while the clock enable is low must be lost
    ce <= 1'b0;
    wr(ADDR_WTM, 8'h05);
    ce <= 1'b1;
    rd(ADDR_WTM);
    check({2'b00, rd_val}, 10'h002);
    $display("test clock enable done");
    give_verdict();
  end

  // watchdog well beyond the expected run length
  initial begin
    #(25 * 20000);
    n_errors++;
    give_verdict();
  end
endmodule
